// [hw/dsos_defines.svh]
// Register offsets, reset values and timing counts of the output selector.
// Assumes a 10 MHz control clock and a 16-bit register port.
`ifndef DSOS_DEFINES_SVH
`define DSOS_DEFINES_SVH

// ==========================================================================
// Register offsets (word index on the register port)
`define DSOS_OFS_STATE      8'h00
`define DSOS_OFS_FILT_TIME  8'h01
`define DSOS_OFS_HYST       8'h02
`define DSOS_OFS_SEL_BASE   8'h03
`define DSOS_OFS_CTRL_MODE  8'h08
`define DSOS_OFS_ZERO_ZONE  8'h09
`define DSOS_OFS_NX         8'h0A
`define DSOS_OFS_NY         8'h0B
`define DSOS_OFS_IX         8'h0C
`define DSOS_OFS_TX         8'h0D
`define DSOS_OFS_FX         8'h0E
`define DSOS_OFS_HX         8'h0F
`define DSOS_OFS_NET        8'h10
`define DSOS_OFS_DLY_BASE   8'h11
`define DSOS_OFS_FILT_IQ    8'h15
`define DSOS_OFS_EQ_BAND    8'h16

// ==========================================================================
// Reset values, limits and control mode codes
`define DSOS_HYST_RESET     16'h00C8
`define DSOS_HYST_MAX       16'h03E7
`define DSOS_FILT_RESET     4'h4
`define DSOS_MODE_RESET     3'h0
`define DSOS_MODE_SENSORLESS 3'h3
`define DSOS_MODE_ENCODER   3'h4

// ==========================================================================
// Timing
`define DSOS_CLK_HZ         10000000
`define DSOS_FILT_PERIOD_MS 2
`define DSOS_DLY_UNIT_MS    100

`endif

// [hw/dsos_pkg.sv]
// Types of the drive status output selector.
// Assumes nothing beyond the defines header.
`default_nettype none

package dsos_pkg;

    // ======================================================================
    // Output function codes
    typedef enum logic [5:0] {
        FN_NOT_USED   = 6'h00,
        FN_REF_GT_NX  = 6'h01,
        FN_N_GT_NX    = 6'h02,
        FN_N_LT_NY    = 6'h03,
        FN_N_EQ_REF   = 6'h04,
        FN_ZERO_SPEED = 6'h05,
        FN_IS_GT_IX   = 6'h06,
        FN_IS_LT_IX   = 6'h07,
        FN_TQ_GT_TX   = 6'h08,
        FN_TQ_LT_TX   = 6'h09,
        FN_REMOTE     = 6'h0A,
        FN_RUN        = 6'h0B,
        FN_READY      = 6'h0C,
        FN_NO_FAULT   = 6'h0D,
        FN_NO_GRP_A   = 6'h0E,
        FN_NO_GRP_B   = 6'h0F,
        FN_NO_GRP_C   = 6'h10,
        FN_NO_GRP_D   = 6'h11,
        FN_NO_GRP_E   = 6'h12,
        FN_LOOP_OK    = 6'h13,
        FN_NETWORK    = 6'h14,
        FN_FORWARD    = 6'h15,
        FN_RIDE_THRU  = 6'h18,
        FN_PRECHARGE  = 6'h19,
        FN_FAULT      = 6'h1A,
        FN_HOURS_GT   = 6'h1B,
        FN_TIMER      = 6'h1D,
        FN_N_AND_NT   = 6'h1E,
        FN_F_GT_FX1   = 6'h1F,
        FN_F_GT_FX2   = 6'h20,
        FN_SAFE_STOP  = 6'h22,
        FN_NO_STOP_F  = 6'h23,
        FN_NO_ALARM   = 6'h24,
        FN_NO_FLT_ALM = 6'h25,
        FN_TQ_POS     = 6'h2B,
        FN_TQ_NEG     = 6'h2C
    } dsos_func_type;

endpackage

`default_nettype wire

// [hw/dsos_top.sv]
// Drive status output selector: five outputs, each showing one status condition.
// Assumes all status inputs are synchronous to clk and register port per house bus.
//
// The implementer's own choices: strobed register access and the register addresses.
`include "dsos_defines.svh"
`default_nettype none

// How it works
// - Read-only word, bit per output, first lowest
// - Torque current low-pass filtered every 2 ms
// - Hysteresis 0 to 9.99 %, default 2.00 %
// - Output follows its condition, registered one clock later
// - Unused code keeps output at rest
// - Zero speed: speed below zero zone
// - Torque compares only in control mode 3/4
// - Ready: no fault and no undervoltage
// - Run: enabled and switching, any speed
// - Forward active forward, inactive reverse
// - No-fault and per-group no-fault indications
// - Fault is complement of no-fault
// - Network function follows network output word
// - Speed and total reference both exceed threshold, in control mode 4 only
// - Code 43 positive torque, 44 negative
// - Hysteresis on both switching edges
// - No-alarm active with no alarm
// - Pre-charge ok above pre-charge level
// - Remote active in remote situation
// - Current loop ok inside 4-20 mA
// - Safe-stop output while safe stop active
// - Relay two/three timer with on/off delays
// - Short input pulse resets timer only
module dsos_top
    import dsos_pkg::*;
#(
    parameter int FILT_TICK_CYCLES = `DSOS_CLK_HZ / 1000 * `DSOS_FILT_PERIOD_MS,
    parameter int DLY_TICK_CYCLES  = `DSOS_CLK_HZ / 1000 * `DSOS_DLY_UNIT_MS
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] speed_reference,
    input  wire logic [15:0] total_speed_reference,
    input  wire logic [15:0] motor_current,
    input  wire logic [15:0] motor_torque,
    input  wire logic [15:0] torque_current,
    input  wire logic [15:0] motor_frequency,
    input  wire logic [15:0] enabled_hours,
    input  wire logic        fault_active,
    input  wire logic [4:0]  fault_group,
    input  wire logic        undervoltage,
    input  wire logic        drive_running,
    input  wire logic        rotating_forward,
    input  wire logic        alarm_active,
    input  wire logic        stop_relay_fault,
    input  wire logic        precharge_ok,
    input  wire logic        remote_mode,
    input  wire logic        current_loop_in_range,
    input  wire logic        ride_through,
    input  wire logic        safe_stop_state,
    input  wire logic        timer_in_two,
    input  wire logic        timer_in_three,
    output logic             relay_out_one,
    output logic             relay_out_two,
    output logic             relay_out_three,
    output logic             open_collector_out_four,
    output logic             open_collector_out_five
);

    // ======================================================================
    // Helpers
    function automatic logic [15:0] abs16(input logic [15:0] v);
        abs16 = v[15] ? 16'(-v) : v;
    endfunction

    function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction

    // ======================================================================
    // Registers
    logic [3:0]    torque_current_filter_time_r;
    logic [15:0]   torque_polarity_hysteresis_r;
    dsos_func_type func_sel_r [5];
    logic [2:0]    control_mode_select_r;
    logic [15:0]   zero_speed_zone_r;
    logic [15:0]   speed_threshold_x_r;
    logic [15:0]   speed_threshold_y_r;
    logic [15:0]   current_threshold_r;
    logic [15:0]   torque_threshold_r;
    logic [15:0]   freq_threshold_r;
    logic [15:0]   hours_threshold_r;
    logic [15:0]   speed_eq_band_r;
    logic [4:0]    network_output_word_r;
    logic [15:0]   delay_r [4];
    logic [15:0]   filt_iq_r;
    logic [4:0]    out_r;
    logic          tq_pos_r;
    logic          tq_neg_r;
    logic [1:0]    timer_out_r;
    logic [15:0]   timer_cnt_r [2];
    logic [4:0]    act;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            torque_current_filter_time_r <= `DSOS_FILT_RESET;
            torque_polarity_hysteresis_r <= `DSOS_HYST_RESET;
            for (int i = 0; i < 5; i++) begin
                func_sel_r[i] <= FN_NOT_USED;
            end
            control_mode_select_r <= `DSOS_MODE_RESET;
            zero_speed_zone_r     <= 16'h0000;
            speed_threshold_x_r   <= 16'h0000;
            speed_threshold_y_r   <= 16'h0000;
            current_threshold_r   <= 16'h0000;
            torque_threshold_r    <= 16'h0000;
            freq_threshold_r      <= 16'h0000;
            hours_threshold_r     <= 16'h0000;
            speed_eq_band_r       <= 16'h0000;
            network_output_word_r <= 5'h00;
            for (int i = 0; i < 4; i++) begin
                delay_r[i] <= 16'h0000;
            end
        end else if (reg_wr) begin
            for (int i = 0; i < 5; i++) begin
                if (reg_addr == `DSOS_OFS_SEL_BASE + 8'(i)) begin
                    func_sel_r[i] <= dsos_func_type'(reg_wdata[5:0]);
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (reg_addr == `DSOS_OFS_DLY_BASE + 8'(i)) begin
                    delay_r[i] <= reg_wdata;
                end
            end
            case (reg_addr)
                `DSOS_OFS_FILT_TIME: torque_current_filter_time_r <= reg_wdata[3:0];
                `DSOS_OFS_HYST: begin
                    // Writes above 9.99 % saturate
                    torque_polarity_hysteresis_r <= (reg_wdata > `DSOS_HYST_MAX) ? `DSOS_HYST_MAX : reg_wdata;
                end
                `DSOS_OFS_CTRL_MODE: control_mode_select_r <= reg_wdata[2:0];
                `DSOS_OFS_ZERO_ZONE: zero_speed_zone_r     <= reg_wdata;
                `DSOS_OFS_NX:        speed_threshold_x_r   <= reg_wdata;
                `DSOS_OFS_NY:        speed_threshold_y_r   <= reg_wdata;
                `DSOS_OFS_IX:        current_threshold_r   <= reg_wdata;
                `DSOS_OFS_TX:        torque_threshold_r    <= reg_wdata;
                `DSOS_OFS_FX:        freq_threshold_r      <= reg_wdata;
                `DSOS_OFS_HX:        hours_threshold_r     <= reg_wdata;
                `DSOS_OFS_EQ_BAND:   speed_eq_band_r       <= reg_wdata;
                `DSOS_OFS_NET:       network_output_word_r <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Read port
    logic [15:0] rd_val;

    always_comb begin
        rd_val = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            if (reg_addr == `DSOS_OFS_SEL_BASE + 8'(i)) begin
                rd_val = {10'h000, func_sel_r[i]};
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (reg_addr == `DSOS_OFS_DLY_BASE + 8'(i)) begin
                rd_val = delay_r[i];
            end
        end
        case (reg_addr)
            `DSOS_OFS_STATE:     rd_val = {11'h000, out_r};
            `DSOS_OFS_FILT_TIME: rd_val = {12'h000, torque_current_filter_time_r};
            `DSOS_OFS_HYST:      rd_val = torque_polarity_hysteresis_r;
            `DSOS_OFS_CTRL_MODE: rd_val = {13'h0000, control_mode_select_r};
            `DSOS_OFS_ZERO_ZONE: rd_val = zero_speed_zone_r;
            `DSOS_OFS_NX:        rd_val = speed_threshold_x_r;
            `DSOS_OFS_NY:        rd_val = speed_threshold_y_r;
            `DSOS_OFS_IX:        rd_val = current_threshold_r;
            `DSOS_OFS_TX:        rd_val = torque_threshold_r;
            `DSOS_OFS_FX:        rd_val = freq_threshold_r;
            `DSOS_OFS_HX:        rd_val = hours_threshold_r;
            `DSOS_OFS_EQ_BAND:   rd_val = speed_eq_band_r;
            `DSOS_OFS_NET:       rd_val = {11'h000, network_output_word_r};
            `DSOS_OFS_FILT_IQ:   rd_val = filt_iq_r;
            default: ;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 16'h0000;
        end
    end

    // ======================================================================
    // Tick dividers
    logic [31:0] filt_div_r;
    logic [31:0] dly_div_r;
    logic        filt_tick;
    logic        dly_tick;

    assign filt_tick = (filt_div_r == 32'(FILT_TICK_CYCLES - 1));
    assign dly_tick  = (dly_div_r == 32'(DLY_TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_div_r <= 32'h0000_0000;
            dly_div_r  <= 32'h0000_0000;
        end else begin
            filt_div_r <= filt_tick ? 32'h0000_0000 : filt_div_r + 32'h0000_0001;
            dly_div_r  <= dly_tick ? 32'h0000_0000 : dly_div_r + 32'h0000_0001;
        end
    end

    // ======================================================================
    // Torque current filter
    logic signed [16:0] filt_diff;

    assign filt_diff = 17'($signed(torque_current)) - 17'($signed(filt_iq_r));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_iq_r <= 16'h0000;
        end else if (filt_tick) begin
            filt_iq_r <= filt_iq_r + 16'(filt_diff >>> torque_current_filter_time_r);
        end
    end

    // ======================================================================
    // Torque polarity
    logic [15:0] hyst_neg;

    assign hyst_neg = 16'(-torque_polarity_hysteresis_r);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tq_pos_r <= 1'b0;
            tq_neg_r <= 1'b0;
        end else begin
            if (sgt(filt_iq_r, torque_polarity_hysteresis_r)) begin
                tq_pos_r <= 1'b1;
            end else if (sgt(hyst_neg, filt_iq_r)) begin
                tq_pos_r <= 1'b0;
            end
            if (sgt(hyst_neg, filt_iq_r)) begin
                tq_neg_r <= 1'b1;
            end else if (sgt(filt_iq_r, torque_polarity_hysteresis_r)) begin
                tq_neg_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Relay two/three timers
    logic [1:0] timer_in;

    assign timer_in = {timer_in_three, timer_in_two};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_out_r <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                timer_cnt_r[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (timer_in[i] == timer_out_r[i]) begin
                    timer_cnt_r[i] <= 16'h0000;
                end else if (timer_cnt_r[i] >= delay_r[2 * i + (timer_in[i] ? 0 : 1)]) begin
                    timer_out_r[i] <= timer_in[i];
                    timer_cnt_r[i] <= 16'h0000;
                end else if (dly_tick) begin
                    timer_cnt_r[i] <= timer_cnt_r[i] + 16'h0001;
                end
            end
        end
    end

    // ======================================================================
    // Function evaluation per output
    logic tq_mode;
    logic enc_mode;

    assign tq_mode  = (control_mode_select_r == `DSOS_MODE_SENSORLESS) ||
                      (control_mode_select_r == `DSOS_MODE_ENCODER);
    assign enc_mode = (control_mode_select_r == `DSOS_MODE_ENCODER);

    function automatic logic eval(input dsos_func_type fn, input int idx);
        logic r;
        r = 1'b0;
        case (fn)
            FN_REF_GT_NX:  r = abs16(speed_reference) > speed_threshold_x_r;
            FN_N_GT_NX:    r = abs16(motor_speed) > speed_threshold_x_r;
            FN_N_LT_NY:    r = abs16(motor_speed) < speed_threshold_y_r;
            FN_N_EQ_REF:   r = abs16(16'(motor_speed - speed_reference)) <= speed_eq_band_r;
            FN_ZERO_SPEED: r = abs16(motor_speed) < zero_speed_zone_r;
            FN_IS_GT_IX:   r = motor_current > current_threshold_r;
            FN_IS_LT_IX:   r = motor_current < current_threshold_r;
            FN_TQ_GT_TX:   r = tq_mode && (abs16(motor_torque) > torque_threshold_r);
            FN_TQ_LT_TX:   r = tq_mode && (abs16(motor_torque) < torque_threshold_r);
            FN_REMOTE:     r = remote_mode;
            FN_RUN:        r = drive_running;
            FN_READY:      r = !fault_active && !undervoltage;
            FN_NO_FAULT:   r = !fault_active;
            FN_NO_GRP_A:   r = !fault_group[0];
            FN_NO_GRP_B:   r = !fault_group[1];
            FN_NO_GRP_C:   r = !fault_group[2];
            FN_NO_GRP_D:   r = !fault_group[3];
            FN_NO_GRP_E:   r = !fault_group[4];
            FN_LOOP_OK:    r = current_loop_in_range;
            FN_NETWORK:    r = network_output_word_r[idx];
            FN_FORWARD:    r = rotating_forward;
            FN_RIDE_THRU:  r = ride_through;
            FN_PRECHARGE:  r = precharge_ok;
            FN_FAULT:      r = fault_active;
            FN_HOURS_GT:   r = enabled_hours > hours_threshold_r;
            FN_TIMER:      r = (idx == 1 || idx == 2) && timer_out_r[(idx == 2) ? 1 : 0];
            FN_N_AND_NT:   r = enc_mode && (abs16(motor_speed) > speed_threshold_x_r) &&
                               (abs16(total_speed_reference) > speed_threshold_x_r);
            FN_F_GT_FX1,
            FN_F_GT_FX2:   r = motor_frequency > freq_threshold_r;
            FN_SAFE_STOP:  r = safe_stop_state;
            FN_NO_STOP_F:  r = !stop_relay_fault;
            FN_NO_ALARM:   r = !alarm_active;
            FN_NO_FLT_ALM: r = !fault_active && !alarm_active;
            FN_TQ_POS:     r = tq_pos_r;
            FN_TQ_NEG:     r = tq_neg_r;
            default:       r = 1'b0;
        endcase
        eval = r;
    endfunction

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            act[i] = eval(func_sel_r[i], i);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_r <= 5'h00;
        end else begin
            out_r <= act;
        end
    end

    assign relay_out_one           = out_r[0];
    assign relay_out_two           = out_r[1];
    assign relay_out_three         = out_r[2];
    assign open_collector_out_four = out_r[3];
    assign open_collector_out_five = out_r[4];

endmodule

`default_nettype wire

// [verif/dsos_chk_sva.sv]
// Checker of the output selector: read-back and output one functions.
// Assumes binding to dsos_top; shadows select one and network bit zero.
`default_nettype none

module dsos_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        fault_active,
    input wire logic        undervoltage,
    input wire logic        drive_running,
    input wire logic        rotating_forward,
    input wire logic        safe_stop_state,
    input wire logic        relay_out_one,
    input wire logic        relay_out_two,
    input wire logic        relay_out_three,
    input wire logic        open_collector_out_four,
    input wire logic        open_collector_out_five
);
    // ==========
    // Shadow registers
    logic [5:0] sel_r;
    logic       net_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) {sel_r, net_r} <= 7'h00;
        else if (reg_wr && reg_addr == 8'h03) sel_r <= reg_wdata[5:0];
        else if (reg_wr && reg_addr == 8'h10) net_r <= reg_wdata[0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========
    // Assertions
    property p_state; reg_rd && reg_addr == 8'h00 |=> reg_rdata == {11'h000, $past({open_collector_out_five,
        open_collector_out_four, relay_out_three, relay_out_two, relay_out_one})}; endproperty
    a_state: assert property (p_state) else $error("state word mismatch");
    property p_unused; sel_r == 6'h00 |=> !relay_out_one; endproperty
    a_unused: assert property (p_unused) else $error("unused output active");
    property p_run; sel_r == 6'h0B |=> relay_out_one == $past(drive_running); endproperty
    a_run: assert property (p_run) else $error("run output wrong");
    property p_ready; sel_r == 6'h0C |=> relay_out_one == $past(!fault_active && !undervoltage); endproperty
    a_ready: assert property (p_ready) else $error("ready output wrong");
    property p_fault; sel_r == 6'h1A ##1 sel_r == 6'h1A |-> relay_out_one == $past(fault_active); endproperty
    a_fault: assert property (p_fault) else $error("fault output wrong");
    property p_fwd; sel_r == 6'h15 |=> relay_out_one == $past(rotating_forward); endproperty
    a_fwd: assert property (p_fwd) else $error("forward output wrong");
    property p_net; sel_r == 6'h14 |=> relay_out_one == $past(net_r); endproperty
    a_net: assert property (p_net) else $error("network output wrong");
    property p_safe; sel_r == 6'h22 |=> relay_out_one == $past(safe_stop_state); endproperty
    a_safe: assert property (p_safe) else $error("safe stop output wrong");
    property p_timer_one; sel_r == 6'h1D |=> !relay_out_one; endproperty
    a_timer_one: assert property (p_timer_one) else $error("timer on output one");
    c_run: cover property (sel_r == 6'h0B && relay_out_one);
    c_net: cover property (sel_r == 6'h14 && relay_out_one);
    c_read: cover property (reg_rd && reg_addr == 8'h00 ##1 reg_rdata != 16'h0000);
endmodule

bind dsos_top dsos_chk dsos_chk_inst (.*);

`default_nettype wire

// [verif/dsos_load_model.sv]
// Load model: relay coils, open-collector loads and a second drive's direction input.
// Assumes active-high selector outputs, energized or saturated when high.
`default_nettype none

module dsos_load_model #(
    parameter bit SLAVE_REVERSED = 1'b0
) (
    input  wire logic       relay_out_one,
    input  wire logic       relay_out_two,
    input  wire logic       relay_out_three,
    input  wire logic       open_collector_out_four,
    input  wire logic       open_collector_out_five,
    output logic      [4:0] load_energized,
    output logic            slave_forward
);
    // ==========
    // Coils and slave direction input
    assign load_energized = {open_collector_out_five, open_collector_out_four, relay_out_three, relay_out_two,
                             relay_out_one};
    assign slave_forward = SLAVE_REVERSED ? open_collector_out_four : !open_collector_out_four;
endmodule

`default_nettype wire

// [verif/tb_dsos_top.sv]
// Testbench of the drive status output selector.
// Assumes design, checker and load model compiled first.
`default_nettype none

module tb_dsos_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset_n, reg_wr, reg_rd;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, motor_speed, speed_reference, total_speed_reference;
    logic [15:0] motor_current, motor_torque, torque_current, motor_frequency, enabled_hours;
    logic [4:0]  fault_group, load_energized;
    logic        fault_active, undervoltage, drive_running, rotating_forward, alarm_active;
    logic        stop_relay_fault, precharge_ok, remote_mode, current_loop_in_range, ride_through;
    logic        safe_stop_state, timer_in_two, timer_in_three, slave_forward;
    logic        relay_out_one, relay_out_two, relay_out_three, open_collector_out_four, open_collector_out_five;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [10:0] st;
    logic [5:0]  codes [13] = '{6'h0C, 6'h0B, 6'h0D, 6'h15, 6'h19, 6'h0A, 6'h13, 6'h22, 6'h24, 6'h0E, 6'h18,
                                6'h23, 6'h25};

    assign {fault_active, undervoltage, alarm_active, stop_relay_fault, drive_running, rotating_forward,
            precharge_ok, remote_mode, current_loop_in_range, ride_through, safe_stop_state} = st;

    dsos_top #(.FILT_TICK_CYCLES(8), .DLY_TICK_CYCLES(10)) dsos_top_inst (.*);
    dsos_load_model #(.SLAVE_REVERSED(1'b1)) dsos_load_model_inst (.*);

    // ==========
    // Clock and timeout
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk_bit(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic fn_chk(input logic [5:0] code, input logic exp);
        wr(8'h03, {10'h000, code});
        tick(3);
        chk_bit(relay_out_one, exp);
    endtask
    task automatic note(input string name);
        $display("%s done, %0d mismatches", name, mismatches);
    endtask
    task automatic close_out();
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========
    // Test sequence
    initial begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, motor_speed, speed_reference, total_speed_reference,
         motor_current, motor_torque, torque_current, motor_frequency, enabled_hours, fault_group, st,
         timer_in_two, timer_in_three} = '0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(8'h02, 16'h00C8);
        rd_chk(8'h01, 16'h0004);
        rd_chk(8'h30, 16'h0000);
        wr(8'h02, 16'h0500);
        rd_chk(8'h02, 16'h03E7);
        wr(8'h02, 16'h00C8);
        wr(8'h00, 16'h001F);
        rd_chk(8'h00, 16'h0000);
        note("registers");
        st <= 11'h07F;
        foreach (codes[i]) fn_chk(codes[i], 1'b1);
        fn_chk(6'h1A, 1'b0);
        fn_chk(6'h00, 1'b0);
        fn_chk(6'h1D, 1'b0);
        fn_chk(6'h26, 1'b0);
        st[9] <= 1'b1;
        fn_chk(6'h0C, 1'b0);
        fn_chk(6'h0D, 1'b1);
        st <= 11'h780;
        fault_group <= 5'h01;
        foreach (codes[i]) fn_chk(codes[i], 1'b0);
        fn_chk(6'h1A, 1'b1);
        fn_chk(6'h0F, 1'b1);
        note("functions");
        for (int a = 3; a < 8; a++) wr(8'(a), 16'h0014);
        wr(8'h10, 16'h0015);
        tick(3);
        rd_chk(8'h00, 16'h0015);
        check({11'h000, load_energized}, 16'h0015);
        wr(8'h10, 16'h000A);
        tick(3);
        rd_chk(8'h00, 16'h000A);
        note("network");
        wr(8'h09, 16'h0032);
        motor_speed <= 16'h000A;
        fn_chk(6'h05, 1'b1);
        motor_speed <= 16'hFFF6;
        fn_chk(6'h05, 1'b1);
        motor_speed <= 16'h0064;
        fn_chk(6'h05, 1'b0);
        wr(8'h0D, 16'h0064);
        motor_torque <= 16'h00C8;
        fn_chk(6'h08, 1'b0);
        wr(8'h08, 16'h0003);
        fn_chk(6'h08, 1'b1);
        fn_chk(6'h09, 1'b0);
        wr(8'h08, 16'h0004);
        fn_chk(6'h08, 1'b1);
        wr(8'h0A, 16'h0064);
        motor_speed <= 16'h00C8;
        total_speed_reference <= 16'h00C8;
        fn_chk(6'h1E, 1'b1);
        total_speed_reference <= 16'h0032;
        fn_chk(6'h1E, 1'b0);
        total_speed_reference <= 16'h00C8;
        wr(8'h08, 16'h0003);
        fn_chk(6'h1E, 1'b0);
        note("thresholds");
        wr(8'h01, 16'h0000);
        wr(8'h06, 16'h002C);
        torque_current <= 16'h012C;
        tick(10);
        fn_chk(6'h2B, 1'b1);
        tick(30);
        chk_bit(relay_out_one, 1'b1);
        chk_bit(open_collector_out_four, 1'b0);
        torque_current <= 16'h0064;
        tick(30);
        chk_bit(relay_out_one, 1'b1);
        torque_current <= 16'hFED4;
        tick(30);
        chk_bit(relay_out_one, 1'b0);
        chk_bit(open_collector_out_four, 1'b1);
        chk_bit(slave_forward, 1'b1);
        torque_current <= 16'hFF9C;
        tick(30);
        chk_bit(open_collector_out_four, 1'b1);
        rd_chk(8'h15, 16'hFF9C);
        note("polarity");
        wr(8'h04, 16'h001D);
        wr(8'h11, 16'h0002);
        wr(8'h12, 16'h0001);
        timer_in_two <= 1'b1;
        tick(5);
        timer_in_two <= 1'b0;
        tick(40);
        chk_bit(relay_out_two, 1'b0);
        timer_in_two <= 1'b1;
        tick(8);
        chk_bit(relay_out_two, 1'b0);
        tick(40);
        chk_bit(relay_out_two, 1'b1);
        timer_in_two <= 1'b0;
        tick(40);
        chk_bit(relay_out_two, 1'b0);
        note("timer");
        close_out();
    end
endmodule

`default_nettype wire
